// [verilog/sbsc_defines.vh]
// Constants, register map and mode codes for the brake and stop control
// How it works
// - Alarm while moving stops motor, drops brake
// - Speed threshold 0..10000 mm/s, default 10
// - Wait time 10..100 x 10 ms, default 50
// - After power off, slow speed engages brake
// - After power off, wait timeout engages brake
// - Zero-speed alarm stop then stopped-brake timing
// - Servo-off stop: brake/hold, brake/coast, coast/coast
// - Group one uses servo-off selector, two separate
// - Main power loss without servo-off: dynamic brake
// - Brake output high releases; drops on alarm/off
// - Stopped: power off delayed 0..50 x 10 ms
// - Group two selector: zero-speed or group-one method
`ifndef SBSC_DEFINES_VH
`define SBSC_DEFINES_VH
// Register byte addresses
`define SBSC_ADDR_CTRL 8'h00
`define SBSC_ADDR_SPD 8'h04
`define SBSC_ADDR_WAIT 8'h08
`define SBSC_ADDR_DELAY 8'h0C
`define SBSC_ADDR_SEL 8'h10
`define SBSC_ADDR_STAT 8'h14
// Limits and reset values
`define SBSC_SPD_MAX 16'h2710
`define SBSC_SPD_RST 16'h000A
`define SBSC_WAIT_MIN 7'h0A
`define SBSC_WAIT_MAX 7'h64
`define SBSC_WAIT_RST 7'h32
`define SBSC_DELAY_MAX 6'h32
`define SBSC_DELAY_RST 6'h00
// Timing: last cycle of a 10 ms tick at 125 MHz (1250000 cycles)
`define SBSC_TICK_LAST 21'h1312CF
// Stop method codes
`define SBSC_SEL_BRAKE_HOLD 2'h0
`define SBSC_SEL_BRAKE_COAST 2'h1
`define SBSC_SEL_COAST 2'h2
`define SBSC_G2_ZERO 1'h0
// AXI responses
`define SBSC_RESP_OKAY 2'h0
`define SBSC_RESP_SLVERR 2'h2
`endif

// [verilog/sbsc_tick_timer.v]
// Ten-millisecond tick counter and unit counter used for brake timing
`timescale 1ns/100ps
module sbsc_tick_timer (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire clear,
  input wire [6:0] limit,
  // Status
  output reg expired_q
);
`include "sbsc_defines.vh"
  // Cycle counter for one tick
  reg [20:0] cyc_q;
  // Tick units elapsed
  reg [6:0] units_q;
  wire tick = (cyc_q == `SBSC_TICK_LAST);
  // Count ticks from the clear, flag once limit is reached
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      cyc_q <= 21'h000000;
      units_q <= 7'h00;
      expired_q <= 1'b0;
    end else begin
      expired_q <= (units_q >= limit);
      if (tick) begin
        cyc_q <= 21'h000000;
        if (units_q != 7'h7F) begin
          units_q <= units_q + 7'h01;
        end
      end else begin
        cyc_q <= cyc_q + 21'h000001;
      end
    end
  end
endmodule

// [verilog/sbsc_brake_ctrl.v]
// Holding brake release output and stop method selection with AXI4-Lite
`timescale 1ns/100ps
module sbsc_brake_ctrl (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Host commands and drive status
  input wire servo_enable_command,
  input wire servo_disable_command,
  input wire alarm_group_one,
  input wire alarm_group_two,
  input wire main_power_lost,
  input wire signed [15:0] motor_speed,
  input wire restart,
  // Drive outputs
  output reg brake_release_output,
  output reg motor_power_on,
  output reg dynamic_brake,
  output reg zero_speed_stop
);
`include "sbsc_defines.vh"
  // States
  localparam ST_OFF = 3'h0;
  localparam ST_RUN = 3'h1;
  localparam ST_ZERO = 3'h2;
  localparam ST_MOVE = 3'h3;
  localparam ST_DELAY = 3'h4;
  reg [2:0] state_q;
  // Settings
  reg [15:0] spd_q;
  reg [6:0] wait_q;
  reg [5:0] delay_q;
  reg [1:0] sel_pend_q;
  reg g2_pend_q;
  reg [1:0] sel_q;
  reg g2_q;
  // Sticky stop cause seen
  reg nocmd_loss_q;
  // Bus holding registers
  reg [7:0] aw_q;
  reg aw_v_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  reg w_v_q;
  // Absolute speed and alarm status
  wire [15:0] abs_spd = motor_speed[15] ? (~motor_speed + 16'h0001) :
                        motor_speed;
  wire alarm = alarm_group_one | alarm_group_two;
  // Slow enough to brake now
  wire slow = abs_spd < spd_q;
  // Group two uses zero-speed unless selector says group-one method
  wire use_zero = alarm_group_two && !alarm_group_one &&
                  (g2_q == `SBSC_G2_ZERO);
  // Timer control
  wire tmr_clr = (state_q != ST_MOVE) && (state_q != ST_DELAY);
  wire [6:0] tmr_lim = (state_q == ST_DELAY) ? {1'b0, delay_q} : wait_q;
  wire tmr_exp;
  sbsc_tick_timer u_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(tmr_clr),
    .limit(tmr_lim),
    .expired_q(tmr_exp)
  );
  // Brake, power and stop state machine
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (servo_enable_command && !alarm && !main_power_lost) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (main_power_lost) begin
            state_q <= slow ? ST_OFF : ST_MOVE;
          end else if (alarm && use_zero) begin
            state_q <= ST_ZERO;
          end else if (alarm || servo_disable_command) begin
            state_q <= slow ? ST_DELAY : ST_MOVE;
          end
        end
        ST_ZERO: begin
          if (slow) begin
            state_q <= ST_DELAY;
          end
        end
        ST_MOVE: begin
          if (slow || tmr_exp) begin
            state_q <= ST_OFF;
          end
        end
        ST_DELAY: begin
          if (tmr_exp || main_power_lost) begin
            state_q <= ST_OFF;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end
  // Outputs from state; brake released only while running
  always @(posedge aclk) begin
    if (!aresetn) begin
      brake_release_output <= 1'b0;
      motor_power_on <= 1'b0;
      dynamic_brake <= 1'b0;
      zero_speed_stop <= 1'b0;
    end else begin
      brake_release_output <= (state_q == ST_RUN) && !alarm &&
                              !servo_disable_command &&
                              !main_power_lost;
      motor_power_on <= (state_q == ST_RUN && !main_power_lost) ||
                        state_q == ST_ZERO || state_q == ST_DELAY;
      zero_speed_stop <= (state_q == ST_ZERO);
      if (nocmd_loss_q) begin
        dynamic_brake <= !motor_power_on;
      end else if (sel_q == `SBSC_SEL_COAST) begin
        dynamic_brake <= 1'b0;
      end else if (sel_q == `SBSC_SEL_BRAKE_COAST) begin
        dynamic_brake <= (state_q == ST_MOVE);
      end else begin
        dynamic_brake <= (state_q == ST_MOVE) || (state_q == ST_OFF);
      end
    end
  end
  // Main power loss without servo-off forces dynamic braking
  always @(posedge aclk) begin
    if (!aresetn) begin
      nocmd_loss_q <= 1'b0;
    end else if (state_q == ST_RUN && main_power_lost) begin
      nocmd_loss_q <= 1'b1;
    end else if (state_q == ST_OFF && servo_enable_command) begin
      nocmd_loss_q <= 1'b0;
    end
  end
  // AXI write path: hold address and data, respond when both are held
  assign s_axi_awready = !aw_v_q && !s_axi_bvalid;
  assign s_axi_wready = !w_v_q && !s_axi_bvalid;
  wire wr_go = aw_v_q && w_v_q;
  wire [31:0] wd = w_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 8'h00;
      aw_v_q <= 1'b0;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
      w_v_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBSC_RESP_OKAY;
      spd_q <= `SBSC_SPD_RST;
      wait_q <= `SBSC_WAIT_RST;
      delay_q <= `SBSC_DELAY_RST;
      sel_pend_q <= `SBSC_SEL_BRAKE_HOLD;
      g2_pend_q <= `SBSC_G2_ZERO;
      sel_q <= `SBSC_SEL_BRAKE_HOLD;
      g2_q <= `SBSC_G2_ZERO;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_v_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_v_q <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Selectors take effect only at restart
      if (restart) begin
        sel_q <= sel_pend_q;
        g2_q <= g2_pend_q;
      end
      if (wr_go) begin
        aw_v_q <= 1'b0;
        w_v_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SBSC_RESP_OKAY;
        case (aw_q)
          `SBSC_ADDR_SPD: begin
            if (ws_q[1:0] == 2'h3 && wd[31:16] == 16'h0000 &&
                wd[15:0] <= `SBSC_SPD_MAX) begin
              spd_q <= wd[15:0];
            end else begin
              s_axi_bresp <= `SBSC_RESP_SLVERR;
            end
          end
          `SBSC_ADDR_WAIT: begin
            if (ws_q[0] && wd[31:7] == 25'h0000000 &&
                wd[6:0] >= `SBSC_WAIT_MIN && wd[6:0] <= `SBSC_WAIT_MAX) begin
              wait_q <= wd[6:0];
            end else begin
              s_axi_bresp <= `SBSC_RESP_SLVERR;
            end
          end
          `SBSC_ADDR_DELAY: begin
            if (ws_q[0] && wd[31:6] == 26'h0000000 &&
                wd[5:0] <= `SBSC_DELAY_MAX) begin
              delay_q <= wd[5:0];
            end else begin
              s_axi_bresp <= `SBSC_RESP_SLVERR;
            end
          end
          `SBSC_ADDR_SEL: begin
            if (ws_q[0] && wd[1:0] != 2'h3) begin
              sel_pend_q <= wd[1:0];
              g2_pend_q <= wd[4];
            end else begin
              s_axi_bresp <= `SBSC_RESP_SLVERR;
            end
          end
          default: begin
            s_axi_bresp <= `SBSC_RESP_SLVERR;
          end
        endcase
      end
    end
  end
  // AXI read path: one-cycle registered answer
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SBSC_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SBSC_RESP_OKAY;
      case (s_axi_araddr)
        `SBSC_ADDR_CTRL: s_axi_rdata <= {27'h0000000, g2_q, 2'h0, sel_q};
        `SBSC_ADDR_SPD: s_axi_rdata <= {16'h0000, spd_q};
        `SBSC_ADDR_WAIT: s_axi_rdata <= {25'h0000000, wait_q};
        `SBSC_ADDR_DELAY: s_axi_rdata <= {26'h0000000, delay_q};
        `SBSC_ADDR_SEL: s_axi_rdata <= {27'h0000000, g2_pend_q, 2'h0,
                                        sel_pend_q};
        `SBSC_ADDR_STAT: s_axi_rdata <= {24'h000000, nocmd_loss_q,
                                         zero_speed_stop, dynamic_brake,
                                         motor_power_on,
                                         brake_release_output, state_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SBSC_RESP_SLVERR;
        end
      endcase
    end
  end
endmodule

// [verif/sbsc_chk_asserts.sv]
// Port checker for the brake and stop control block
`timescale 1ns/100ps
module sbsc_chk (
  // Clock and reset
  input wire aclk, aresetn,
  // Bus handshakes
  input wire s_axi_awready, s_axi_bvalid, s_axi_bready,
  input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // Commands and status
  input wire servo_enable_command, servo_disable_command,
  input wire alarm_group_one, alarm_group_two, main_power_lost,
  // Drive outputs
  input wire brake_release_output, motor_power_on,
  input wire dynamic_brake, zero_speed_stop
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Every stop cause drops the release at the next edge
  property p_drop;
    (alarm_group_one || alarm_group_two || servo_disable_command ||
      main_power_lost) |=> !brake_release_output;
  endproperty
  a_drop: assert property (p_drop) else $error("release held");
  // Release only follows a servo-on request free of alarms
  property p_rise;
    $rose(brake_release_output) |-> !$past(alarm_group_one) &&
      !$past(alarm_group_two) && !$past(main_power_lost) &&
      ($past(servo_enable_command) || $past(servo_enable_command, 2));
  endproperty
  a_rise: assert property (p_rise) else $error("stray release");
  // A released brake needs a powered motor
  property p_pwr;
    brake_release_output |-> motor_power_on;
  endproperty
  a_pwr: assert property (p_pwr) else $error("release unpowered");
  // Zero-speed decel keeps the brake applied
  property p_zero;
    zero_speed_stop |-> !brake_release_output;
  endproperty
  a_zero: assert property (p_zero) else $error("zero stop released");
  // Power loss in run forces the dynamic brake
  property p_loss;
    main_power_lost && brake_release_output |-> ##[1:2] dynamic_brake;
  endproperty
  a_loss: assert property (p_loss) else $error("no brake on loss");
  // Dynamic braking never overlaps motor power
  property p_dbrk;
    dynamic_brake |-> !motor_power_on;
  endproperty
  a_dbrk: assert property (p_dbrk) else $error("braking powered");
  // Write response stands until taken
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  // Read answer one edge after the address is taken
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("late read data");
  // No new write while a response is pending
  property p_awblk;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_awblk: assert property (p_awblk) else $error("write overlap");
endmodule
bind sbsc_brake_ctrl sbsc_chk sbsc_chk_i (.*);

// [verif/sbsc_motor.sv]
// Behavioural motor mechanics standing behind the drive outputs
`timescale 1ns/100ps
module sbsc_motor (
  // Clock
  input wire aclk,
  // Drive side, brake output sensed on its own line
  input wire motor_power_on,
  input wire dynamic_brake,
  input wire brake_release_output,
  input wire signed [15:0] run_speed,
  // Measured speed
  output logic signed [15:0] motor_speed
);
  logic signed [15:0] st; // Decay per cycle
  initial motor_speed = '0;
  assign st = dynamic_brake ? 16'sh2 : 16'sh1;
  // Runs at target while driven, else slows toward rest
  always @(posedge aclk) begin
    if (motor_power_on && brake_release_output)
      motor_speed <= run_speed;
    else if (motor_speed > 16'sh1)
      motor_speed <= motor_speed - st;
    else if (motor_speed < -16'sh1)
      motor_speed <= motor_speed + st;
    else
      motor_speed <= '0;
  end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the brake and stop control block
`timescale 1ns/100ps
`include "sbsc_defines.vh"
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, restart;
  logic servo_enable_command, servo_disable_command, main_power_lost;
  logic alarm_group_one, alarm_group_two, brake_release_output;
  logic motor_power_on, dynamic_brake, zero_speed_stop, ta, tw;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng, v, act;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [15:0] motor_speed, run_speed;
  logic [33:0] exp_q[$]; // Expected bus answers
  int miscompares = 0, total_checks = 0, cyc = 0, n;
  sbsc_brake_ctrl sbsc_brake_ctrl_i (.*);
  sbsc_motor sbsc_motor_i (.*);
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  task automatic check(input [33:0] seen, input [33:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Ceiling on run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test;
    end
  end
  // Watcher pairs each bus answer with the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      check({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  // Waits for a level sampled high at a falling edge
  // Code k: 0 bvalid, 1 arready, 2 rvalid, 3 brake release
  task automatic wait_hi(input int k);
    logic t;
    do begin
      @(negedge aclk);
      t = k == 0 ? s_axi_bvalid : k == 1 ? s_axi_arready :
          k == 2 ? s_axi_rvalid : brake_release_output;
      @(posedge aclk);
    end while (!t);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !ta || s_axi_wvalid && !tw);
    wait_hi(0);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input [7:0] a, input [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    wait_hi(1);
    s_axi_arvalid <= 1'b0;
    wait_hi(2);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Pending selector only takes hold at restart
  task automatic sel_set(input [31:0] s);
    wr(`SBSC_ADDR_SEL, s, `SBSC_RESP_OKAY);
    rd(`SBSC_ADDR_CTRL, {`SBSC_RESP_OKAY, act});
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
    act = s;
    rd(`SBSC_ADDR_CTRL, {`SBSC_RESP_OKAY, act});
  endtask
  task automatic run_up;
    servo_enable_command <= 1'b1;
    wait_hi(3);
    check(motor_power_on, 1'b1);
    repeat (4) @(posedge aclk);
  endtask
  // Stop cause k: group one, group two, power loss
  task automatic stop_case(input int k, input logic dyn, input logic zs);
    run_up;
    if (k == 0) alarm_group_one <= 1'b1;
    if (k == 1) alarm_group_two <= 1'b1;
    if (k == 2) main_power_lost <= 1'b1;
    repeat (3) @(posedge aclk);
    check(brake_release_output, 1'b0);
    check(dynamic_brake, dyn);
    check(zero_speed_stop, zs);
    servo_enable_command <= 1'b0;
    repeat (400) @(posedge aclk);
    {alarm_group_one, alarm_group_two, main_power_lost} <= 3'h0;
    @(posedge aclk);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, restart, servo_enable_command} = 3'h0;
    {servo_disable_command, alarm_group_one, alarm_group_two} = 3'h0;
    {main_power_lost, aresetn, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, act} = 64'h0;
    s_axi_wstrb = 4'hF;
    run_speed = 16'sh12C;
    rng = 32'hC7BB;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SBSC_ADDR_SPD, {`SBSC_RESP_OKAY, 16'h0, `SBSC_SPD_RST});
    rd(`SBSC_ADDR_WAIT, {`SBSC_RESP_OKAY, 25'h0, `SBSC_WAIT_RST});
    rd(`SBSC_ADDR_DELAY, {`SBSC_RESP_OKAY, 26'h0, `SBSC_DELAY_RST});
    rd(8'h18, {`SBSC_RESP_SLVERR, 32'h0});
    rd(`SBSC_ADDR_STAT, {`SBSC_RESP_OKAY, 32'h20});
    for (n = 0; n < 4; n++) begin
      rng = xs(rng);
      v = rng % 32'h2711;
      wr(`SBSC_ADDR_SPD, v, `SBSC_RESP_OKAY);
      rd(`SBSC_ADDR_SPD, {`SBSC_RESP_OKAY, v});
    end
    wr(`SBSC_ADDR_SPD, 32'h2711, `SBSC_RESP_SLVERR);
    wr(`SBSC_ADDR_WAIT, 32'h9, `SBSC_RESP_SLVERR);
    wr(`SBSC_ADDR_WAIT, 32'h65, `SBSC_RESP_SLVERR);
    wr(`SBSC_ADDR_DELAY, 32'h33, `SBSC_RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(`SBSC_ADDR_SPD, 32'h5, `SBSC_RESP_SLVERR);
    s_axi_wstrb <= 4'hF;
    wr(`SBSC_ADDR_WAIT, 32'h64, `SBSC_RESP_OKAY);
    rd(`SBSC_ADDR_WAIT, {`SBSC_RESP_OKAY, 32'h64});
    wr(`SBSC_ADDR_SPD, 32'h64, `SBSC_RESP_OKAY);
    // Re-release waits for the speed to fall under threshold
    for (n = 0; n < 2; n++) begin
      rng = xs(rng);
      run_speed <= (n ? -16'sh1 : 16'sh1) * (16'shC8 + rng[7:0]);
      run_up;
      servo_disable_command <= 1'b1;
      @(posedge aclk);
      servo_disable_command <= 1'b0;
      repeat (20) @(posedge aclk);
      check(brake_release_output, 1'b0);
      wait_hi(3);
      check(motor_speed < 16'sh64 && motor_speed > -16'sh64, 1'b1);
      {servo_enable_command, servo_disable_command} <= 2'h1;
      repeat (400) @(posedge aclk);
      servo_disable_command <= 1'b0;
    end
    stop_case(0, 1'b1, 1'b0);
    stop_case(1, 1'b0, 1'b1);
    sel_set(32'h1);
    stop_case(0, 1'b1, 1'b0);
    sel_set(32'h2);
    stop_case(0, 1'b0, 1'b0);
    stop_case(2, 1'b1, 1'b0);
    sel_set(32'h10);
    stop_case(1, 1'b1, 1'b0);
    finish_test;
  end
endmodule
